// ==== gesl_params.svh ====
`ifndef GESL_PARAMS_SVH
`define GESL_PARAMS_SVH
`define GESL_STATUS_ADDR      32'hc0010131
`define GESL_EN_BASE_BIT      1
`define GESL_EN_REGENC_BIT    2
`define GESL_EN_FORCE_BIT     5
`define GESL_PF_RSVD_BIT      3
`define GESL_EX_NPF           12'h400
`define GESL_EX_CALL          12'h403
`define GESL_EX_INVALID       3'd1
`define GESL_EX_BUSY          3'd2
`define GESL_EX_IDLE          3'd3
`define GESL_EX_PMC           3'd4
`define GESL_STATUS_RESET     64'h0
`endif

// ==== gesl_pkg.sv ====
package gesl_pkg;
	typedef enum logic [1:0]
	{
		GESL_HOST  = 2'b00,
		GESL_GUEST = 2'b01,
		GESL_EXIT  = 2'b11
	} gesl_state_t;
endpackage

// ==== gesl_guest_exit_status_logic.sv ====
`timescale 1ns/100ps
`include "gesl_params.svh"
module gesl_guest_exit_status_logic #(
	parameter int ADDR_W = 52
)(
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic              entry_i,
	input  wire logic [7:0]        enable_word_i,
	input  wire logic              branch_rec_virt_i,
	input  wire logic [21:0]       feature_vector_i,
	input  wire logic              status_rd_i,
	input  wire logic [31:0]       status_addr_i,
	output logic      [63:0]       status_rdata_o,
	output logic                   status_hit_o,
	input  wire logic              exit_req_i,
	input  wire logic [11:0]       exit_code_i,
	input  wire logic              exit_neg_i,
	input  wire logic [2:0]        exit_neg_code_i,
	input  wire logic              intercept_i,
	input  wire logic [31:0]       fault_code_field_i,
	input  wire logic              mem_c_bit_i,
	input  wire logic [ADDR_W-1:0] mem_gpa_i,
	input  wire logic [5:0]        c_bit_pos_i,
	output logic                   mem_c_bit_o,
	output logic      [ADDR_W-1:0] nested_gpa_o,
	output logic                   automatic_exit_o,
	output logic                   guest_comm_exception_o,
	output logic      [63:0]       exit_reason_field_o,
	output logic                   rip_advance_o,
	output logic                   save_regs_o,
	output logic                   restore_regs_o,
	output logic                   insn_bytes_we_o,
	output logic                   config_error_o
);
	gesl_pkg::gesl_state_t state_q, state_d;
	logic [63:0] status_q, status_d;
	logic        force_q, force_d;
	logic        regenc_q, regenc_d;
	logic        ae_q, ae_d, vc_q, vc_d, adv_q, adv_d, sv_q, sv_d;
	logic        rs_q, rs_d;
	logic [63:0] code_q, code_d;
	logic        is_ae, is_adv;
	logic [63:0] feat_map;

	// Feature mirror built once per bit; gaps stay zero
	always_comb
	begin
		feat_map = `GESL_STATUS_RESET;
		feat_map[0] = enable_word_i[`GESL_EN_BASE_BIT];
		feat_map[1] = enable_word_i[`GESL_EN_REGENC_BIT];
		feat_map[14:2] = feature_vector_i[12:0];
		feat_map[18:16] = feature_vector_i[16:14];
		feat_map[23] = feature_vector_i[21];
	end

	// Exit classification
	always_comb
	begin
		is_ae = 1'b0;
		is_adv = 1'b0;
		if (exit_neg_i)
			is_ae = 1'b1;
		else
		begin
			case (exit_code_i)
				12'h052, 12'h060, 12'h061, 12'h062, 12'h063, 12'h064,
				12'h07f, 12'h0a5:
					is_ae = 1'b1;
				12'h077, 12'h078, 12'h08f, 12'h0a6, `GESL_EX_CALL:
				begin
					is_ae = 1'b1;
					is_adv = 1'b1;
				end
				`GESL_EX_NPF:
					is_ae = !fault_code_field_i[`GESL_PF_RSVD_BIT];
				default:
					if (exit_code_i[11:4] == 8'h09)
					begin
						is_ae = 1'b1;
						is_adv = 1'b1;
					end
			endcase
		end
	end

	always_comb
	begin
		state_d = state_q;
		status_d = status_q;
		force_d = force_q;
		regenc_d = regenc_q;
		ae_d = 1'b0;
		vc_d = 1'b0;
		adv_d = 1'b0;
		sv_d = 1'b0;
		rs_d = 1'b0;
		code_d = code_q;
		case (state_q)
			gesl_pkg::GESL_HOST:
				if (entry_i)
				begin
					// Latched only here; no write path exists
					status_d = feat_map;
					regenc_d = enable_word_i[`GESL_EN_REGENC_BIT];
					force_d = enable_word_i[`GESL_EN_FORCE_BIT]
						&& enable_word_i[`GESL_EN_BASE_BIT]
						&& !enable_word_i[`GESL_EN_REGENC_BIT];
					rs_d = enable_word_i[`GESL_EN_REGENC_BIT];
					state_d = gesl_pkg::GESL_GUEST;
				end
			gesl_pkg::GESL_GUEST:
				// Errors bypass intercept; others need it
				if (exit_req_i && (intercept_i || exit_neg_i))
				begin
					if (!regenc_q || is_ae)
					begin
						ae_d = 1'b1;
						adv_d = regenc_q && is_adv;
						sv_d = regenc_q;
						code_d = exit_neg_i
							? -{61'h0, exit_neg_code_i}
							: {52'h0, exit_code_i};
						state_d = gesl_pkg::GESL_EXIT;
					end
					else
					begin
						vc_d = 1'b1;
						code_d = {52'h0, exit_code_i};
					end
				end
			gesl_pkg::GESL_EXIT:
				state_d = gesl_pkg::GESL_HOST;
			default:
				state_d = gesl_pkg::GESL_HOST;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state_q <= gesl_pkg::GESL_HOST;
			status_q <= `GESL_STATUS_RESET;
			force_q <= 1'b0;
			regenc_q <= 1'b0;
			ae_q <= 1'b0;
			vc_q <= 1'b0;
			adv_q <= 1'b0;
			sv_q <= 1'b0;
			rs_q <= 1'b0;
			code_q <= 64'h0;
		end
		else
		begin
			state_q <= state_d;
			status_q <= status_d;
			force_q <= force_d;
			regenc_q <= regenc_d;
			ae_q <= ae_d;
			vc_q <= vc_d;
			adv_q <= adv_d;
			sv_q <= sv_d;
			rs_q <= rs_d;
			code_q <= code_d;
		end
	end

	// Read port; hit is never gated by intercepts
	assign status_hit_o = status_rd_i
		&& (status_addr_i == `GESL_STATUS_ADDR);
	assign status_rdata_o = status_hit_o ? status_q : 64'h0;

	// Combinational so the memory path sees no extra latency
	assign mem_c_bit_o = force_q ? 1'b1 : mem_c_bit_i;
	always_comb
	begin
		nested_gpa_o = mem_gpa_i;
		nested_gpa_o[c_bit_pos_i] = 1'b0;
	end

	assign automatic_exit_o = ae_q;
	assign guest_comm_exception_o = vc_q;
	assign exit_reason_field_o = code_q;
	assign rip_advance_o = adv_q;
	assign save_regs_o = sv_q;
	assign restore_regs_o = rs_q;
	assign insn_bytes_we_o = ae_q && !regenc_q
		&& (code_q == {52'h0, `GESL_EX_NPF});
	// Flags a mis-programmed entry; hardware does not refuse it
	assign config_error_o = (state_q != gesl_pkg::GESL_HOST) && regenc_q
		&& !(status_q[0] && branch_rec_virt_i);

	a_force_cbit: assert property (@(posedge mclk_i) disable iff (reset_i)
		force_q |-> mem_c_bit_o)
		else $error("forced encryption not applied");
	a_force_cond: assert property (@(posedge mclk_i) disable iff (reset_i)
		force_q |-> status_q[0] && !status_q[1])
		else $error("forced encryption in wrong mode");
	a_npf_rsvd: assert property (@(posedge mclk_i) disable iff (reset_i)
		state_q == gesl_pkg::GESL_GUEST && regenc_q && exit_req_i
		&& intercept_i && !exit_neg_i && exit_code_i == `GESL_EX_NPF
		&& fault_code_field_i[3] |=> guest_comm_exception_o && !automatic_exit_o)
		else $error("reserved nested fault not delivered to guest");
	a_no_bytes: assert property (@(posedge mclk_i) disable iff (reset_i)
		regenc_q |-> !insn_bytes_we_o)
		else $error("instruction bytes written");
	a_status_rsvd: assert property (@(posedge mclk_i) disable iff (reset_i)
		status_q[63:24] == 40'h0 && status_q[22:19] == 4'h0 && !status_q[15])
		else $error("reserved status bit set");
	a_no_icpt: assert property (@(posedge mclk_i) disable iff (reset_i)
		exit_req_i && !intercept_i && !exit_neg_i
		|=> !automatic_exit_o && !guest_comm_exception_o)
		else $error("exit without intercept");
	a_adv_ae: assert property (@(posedge mclk_i) disable iff (reset_i)
		rip_advance_o |-> automatic_exit_o && save_regs_o)
		else $error("advance without automatic exit");
	a_entry_latch: assert property (@(posedge mclk_i) disable iff (reset_i)
		state_q == gesl_pkg::GESL_HOST && entry_i
		|=> status_q[1] == $past(enable_word_i[2]) && restore_regs_o == status_q[1])
		else $error("status not latched at entry");
endmodule

// ==== gesl_guest_exit_status_logic_bench.sv ====
`timescale 1ns/100ps
module gesl_guest_exit_status_logic_bench;
	logic        mclk_i = 0, reset_i = 1, entry_i = 0, branch_rec_virt_i = 0;
	logic        status_rd_i = 0, exit_req_i = 0, exit_neg_i = 0;
	logic        intercept_i = 0, mem_c_bit_i = 0, chk = 0;
	logic [7:0]  enable_word_i = 0;
	logic [21:0] feature_vector_i = 0;
	logic [31:0] status_addr_i = 0, fault_code_field_i = 0;
	logic [11:0] exit_code_i = 0;
	logic [2:0]  exit_neg_code_i = 0;
	logic [51:0] mem_gpa_i = 0, nested_gpa_o;
	logic [5:0]  c_bit_pos_i = 0;
	logic [63:0] status_rdata_o, exit_reason_field_o;
	logic        status_hit_o, mem_c_bit_o, automatic_exit_o, save_regs_o;
	logic        guest_comm_exception_o, rip_advance_o, restore_regs_o;
	logic        insn_bytes_we_o, config_error_o;
	logic [71:0] notes[$];
	logic [12:0] tbl[20] = '{13'h052, 13'h060, 13'h062, 13'h064, 13'h077,
		13'h078, 13'h07f, 13'h08f, 13'h090, 13'h09f, 13'h0a5, 13'h0a6,
		13'h400, 13'h1400, 13'h403, 13'h065, 13'h07b, 13'h0a7, 13'h401, 13'h08e};
	logic [7:0]  cfg[7] = '{8'h02, 8'h22, 8'h26, 8'h24, 8'h04, 8'h23, 8'h20};
	int          bad_count = 0, compares = 0;
	gesl_guest_exit_status_logic gesl_guest_exit_status_logic_inst (
		.mclk_i(mclk_i), .reset_i(reset_i), .entry_i(entry_i),
		.enable_word_i(enable_word_i), .branch_rec_virt_i(branch_rec_virt_i),
		.feature_vector_i(feature_vector_i), .status_rd_i(status_rd_i),
		.status_addr_i(status_addr_i), .status_rdata_o(status_rdata_o),
		.status_hit_o(status_hit_o), .exit_req_i(exit_req_i),
		.exit_code_i(exit_code_i), .exit_neg_i(exit_neg_i),
		.exit_neg_code_i(exit_neg_code_i), .intercept_i(intercept_i),
		.fault_code_field_i(fault_code_field_i), .mem_c_bit_i(mem_c_bit_i),
		.mem_gpa_i(mem_gpa_i), .c_bit_pos_i(c_bit_pos_i),
		.mem_c_bit_o(mem_c_bit_o), .nested_gpa_o(nested_gpa_o),
		.automatic_exit_o(automatic_exit_o), .save_regs_o(save_regs_o),
		.guest_comm_exception_o(guest_comm_exception_o),
		.exit_reason_field_o(exit_reason_field_o), .rip_advance_o(rip_advance_o),
		.restore_regs_o(restore_regs_o), .insn_bytes_we_o(insn_bytes_we_o),
		.config_error_o(config_error_o));
	initial
	begin
		forever #4 mclk_i = ~mclk_i;
	end
	function automatic logic is_adv(logic [11:0] c);
		return c inside {12'h077, 12'h078, 12'h08f, [12'h090:12'h09f], 12'h0a6, 12'h403};
	endfunction
	function automatic logic is_ae(logic [11:0] c, logic pf);
		return is_adv(c) | (c inside {12'h052, [12'h060:12'h064], 12'h07f, 12'h0a5})
			| (c == 12'h400 & ~pf);
	endfunction
	task automatic check(input logic [71:0] got);
		logic [71:0] exp;
		compares++;
		exp = notes.size() ? notes.pop_front() : 'x;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value result exp %h got %h", exp, got);
		end
	endtask
	// Outputs settle one step after the edge; pulses last a whole cycle
	initial
	begin
		forever
		begin
			@(posedge mclk_i);
			#1;
			if (status_rd_i) check({7'h0, status_hit_o, status_rdata_o});
			if (restore_regs_o !== 1'b0) check({71'h0, restore_regs_o});
			if ((automatic_exit_o | guest_comm_exception_o) !== 1'b0)
				check({3'h0, automatic_exit_o, guest_comm_exception_o, rip_advance_o,
					save_regs_o, insn_bytes_we_o,
					automatic_exit_o ? exit_reason_field_o : 64'h0});
			if (chk) check({18'h0, config_error_o, mem_c_bit_o, nested_gpa_o});
		end
	end
	task automatic rd(input logic [31:0] a, input logic [64:0] e);
		@(negedge mclk_i);
		status_rd_i = 1;
		status_addr_i = a;
		notes.push_back({7'h0, e});
		@(negedge mclk_i);
		status_rd_i = 0;
	endtask
	task automatic enter(input logic [7:0] ew);
		logic [21:0] f;
		@(negedge mclk_i);
		f = 22'($urandom);
		enable_word_i = ew;
		branch_rec_virt_i = ew[2];
		feature_vector_i = f;
		entry_i = 1;
		if (ew[2]) notes.push_back(72'h1);
		@(negedge mclk_i);
		entry_i = 0;
		rd(32'hc0010131, {1'b1, 40'h0, f[21], 4'h0, f[16:14], 1'b0, f[12:0], ew[2:1]});
		mem_c_bit_i = $urandom;
		mem_gpa_i = 52'({$urandom, $urandom});
		c_bit_pos_i = 6'($urandom % 52);
		chk = 1;
		notes.push_back({18'h0, ew[2] & ~ew[1], mem_c_bit_i | (ew[5] & ew[1] & ~ew[2]),
			mem_gpa_i & ~(52'h1 << c_bit_pos_i)});
		@(negedge mclk_i);
		chk = 0;
	endtask
	task automatic leave(input logic [12:0] c, input logic ng, icpt, input logic [7:0] ew);
		logic ae;
		logic enc;
		enc = ew[2];
		ae = ng | ~enc | is_ae(c[11:0], c[12]);
		@(negedge mclk_i);
		exit_req_i = 1;
		exit_code_i = c[11:0];
		exit_neg_i = ng;
		exit_neg_code_i = c[2:0];
		intercept_i = icpt;
		fault_code_field_i = {$urandom} & ~32'h8 | {28'h0, c[12], 3'h0};
		if (icpt | ng) notes.push_back({3'h0, ae, ~ae, enc & ~ng & is_adv(c[11:0]), ae & enc,
			ae & ~enc & ~ng & c[11:0] == 12'h400, ae ? (ng ? -64'(c[2:0]) : 64'(c[11:0]))
			: 64'h0});
		@(negedge mclk_i);
		exit_req_i = 0;
		repeat (3) @(negedge mclk_i);
	endtask
	task automatic end_of_test;
		// Results never seen count as mismatches
		bad_count += notes.size();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		bad_count++;
		end_of_test;
	end
	initial
	begin
		void'($urandom(3));
		repeat (5) @(negedge mclk_i);
		reset_i = 0;
		rd(32'hc0010131, 65'h1_0000_0000_0000_0000);
		rd(32'hc0010130, 65'h0);
		$display("test 1 done");
		foreach (tbl[i])
		begin
			enter(8'h06);
			leave(tbl[i], 0, 1, 8'h06);
			if (!is_ae(tbl[i][11:0], tbl[i][12])) leave(13'(i % 4 + 1), 1, 0, 8'h06);
		end
		$display("test 2 done");
		foreach (cfg[i])
		begin
			enter(cfg[i]);
			leave(13'h400, 0, 1, cfg[i]);
		end
		$display("test 3 done");
		enter(8'h06);
		leave(13'h078, 0, 0, 8'h06);
		leave(13'h003, 1, 0, 8'h06);
		$display("test 4 done");
		repeat (4) @(negedge mclk_i);
		end_of_test;
	end
endmodule
